// file: rtl/rcl_eng_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rcl_eng_if;
	import rcl_pkg::*;
	logic       req;
	rcl_cmd_t   cmd;
	logic [7:0] wdata;
	logic       ack_n;
	logic       done;
	logic       lost;
	logic [7:0] rdata;
	logic       nack;
	logic       scl_s;
	logic       sda_s;
	logic       scl_oe;
	logic       sda_oe;
	modport eng (
		input  req, cmd, wdata, ack_n, scl_s, sda_s,
		output done, lost, rdata, nack, scl_oe, sda_oe
	);
	modport ctl (
		output req, cmd, wdata, ack_n, scl_s, sda_s,
		input  done, lost, rdata, nack, scl_oe, sda_oe
	);
endinterface
`default_nettype wire

// file: rtl/rcl_i2c_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcl_map.svh"
module rcl_i2c_engine (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_sys_rst,
	// Command side
	rcl_eng_if.eng    bus
);
	import rcl_pkg::*;

	localparam logic [11:0] LOW_C  = 12'(`RCL_SCL_LOW_CYC);
	localparam logic [11:0] HIGH_C = 12'(`RCL_SCL_HIGH_CYC);
	localparam logic [11:0] SUSTA  = 12'(`RCL_SU_STA_CYC);
	localparam logic [11:0] HDSTA  = 12'(`RCL_HD_STA_CYC);
	localparam logic [11:0] HDDAT  = 12'(`RCL_HD_DAT_CYC);
	localparam logic [11:0] SUSTO  = 12'(`RCL_SU_STO_CYC);

	typedef enum logic [2:0] {
		E_IDLE, E_STA_HI, E_STA_LO, E_LOW, E_HIGH, E_STO_LO, E_STO_HI
	} rcl_eng_st_t;

	rcl_eng_st_t st_q;
	rcl_cmd_t    cmd_q;
	logic [11:0] cnt_q;
	logic [8:0]  sh_q;
	logic [8:0]  rx_q;
	logic [3:0]  bit_q;

	wire arb_lose = (cmd_q == RCL_CMD_WRITE) && (bit_q < 4'h8) && sh_q[8] && !bus.sda_s;

	assign bus.rdata = rx_q[8:1];
	assign bus.nack  = rx_q[0];

	// ----------------------------------------
	// Bit sequencer
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q       <= E_IDLE;
			cmd_q      <= RCL_CMD_START;
			cnt_q      <= 12'h000;
			sh_q       <= 9'h1FF;
			rx_q       <= 9'h000;
			bit_q      <= 4'h0;
			bus.scl_oe <= 1'b0;
			bus.sda_oe <= 1'b0;
			bus.done   <= 1'b0;
			bus.lost   <= 1'b0;
		end else begin
			bus.done <= 1'b0;
			bus.lost <= 1'b0;
			cnt_q    <= cnt_q + 12'h001;
			unique case (st_q)
				E_IDLE: begin
					// Low phase keeps counting over the command gap
					if (!bus.scl_oe) begin
						cnt_q <= 12'h000;
					end
					bit_q <= 4'h0;
					if (bus.req) begin
						cmd_q <= bus.cmd;
						sh_q  <= (bus.cmd == RCL_CMD_WRITE) ? {bus.wdata, 1'b1} : {8'hFF, bus.ack_n};
						st_q  <= (bus.cmd == RCL_CMD_START) ? E_STA_HI :
						         (bus.cmd == RCL_CMD_STOP) ? E_STO_LO : E_LOW;
					end
				end
				E_STA_HI: begin
					bus.sda_oe <= 1'b0;
					if (bus.scl_oe) begin
						if (cnt_q == LOW_C - 12'h001) begin
							bus.scl_oe <= 1'b0;
							cnt_q      <= 12'h000;
						end
					end else if (!bus.sda_s && cnt_q > 12'h002) begin
						bus.lost <= 1'b1;
						bus.done <= 1'b1;
						st_q     <= E_IDLE;
					end else if (!bus.scl_s) begin
						cnt_q <= 12'h000;
					end else if (cnt_q == SUSTA - 12'h001) begin
						bus.sda_oe <= 1'b1;
						cnt_q      <= 12'h000;
						st_q       <= E_STA_LO;
					end
				end
				E_STA_LO: begin
					if (cnt_q == HDSTA - 12'h001) begin
						cnt_q      <= 12'h000;
						bus.scl_oe <= 1'b1;
						bus.done   <= 1'b1;
						st_q       <= E_IDLE;
					end
				end
				E_LOW: begin
					bus.scl_oe <= 1'b1;
					if (cnt_q == HDDAT) begin
						bus.sda_oe <= ~sh_q[8];
					end
					if (cnt_q == LOW_C - 12'h001) begin
						bus.scl_oe <= 1'b0;
						cnt_q      <= 12'h000;
						st_q       <= E_HIGH;
					end
				end
				E_HIGH: begin
					if (!bus.scl_s) begin
						cnt_q <= 12'h000;
					end else if (cnt_q == (HIGH_C >> 1)) begin
						rx_q <= {rx_q[7:0], bus.sda_s};
						if (arb_lose) begin
							bus.sda_oe <= 1'b0;
							bus.lost   <= 1'b1;
							bus.done   <= 1'b1;
							st_q       <= E_IDLE;
						end
					end else if (cnt_q == HIGH_C - 12'h001) begin
						bus.scl_oe <= 1'b1;
						sh_q       <= {sh_q[7:0], 1'b1};
						bit_q      <= bit_q + 4'h1;
						cnt_q      <= 12'h000;
						st_q       <= (bit_q == 4'h8) ? E_IDLE : E_LOW;
						bus.done   <= (bit_q == 4'h8);
					end
				end
				E_STO_LO: begin
					bus.scl_oe <= 1'b1;
					if (cnt_q == HDDAT) begin
						bus.sda_oe <= 1'b1;
					end
					if (cnt_q == LOW_C - 12'h001) begin
						bus.scl_oe <= 1'b0;
						cnt_q      <= 12'h000;
						st_q       <= E_STO_HI;
					end
				end
				E_STO_HI: begin
					if (!bus.scl_s) begin
						cnt_q <= 12'h000;
					end else if (cnt_q == SUSTO - 12'h001) begin
						bus.sda_oe <= 1'b0;
						bus.done   <= 1'b1;
						st_q       <= E_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: rtl/rcl_map.svh
// Function
// - Pin mode: all control settings come from strap levels, no register access.
// - Master mode: read settings from EEPROM, then drive load-complete low.
// - Single device load completes nominally 7.5 ms after load request.
// - Slave writes accepted before, during, after load; masters must arbitrate.
// - Slave mode: configured only by bus master writing our slave address.
// - Master mode strap L1: generate two-wire clock at nominal 303 kHz.
// - Mode strap at L0 selects pin configuration mode.
`ifndef RCL_MAP_SVH
`define RCL_MAP_SVH

// ----------------------------------------
// Clock rate and bus timing
// ----------------------------------------
`define RCL_CLK_MHZ      250
`define RCL_SCL_LOW_NS   1900
`define RCL_SCL_HIGH_NS  1400
`define RCL_SU_STA_NS    2000
`define RCL_HD_STA_NS    1500
`define RCL_HD_DAT_NS    500
`define RCL_SU_STO_NS    1500
`define RCL_SCL_LOW_CYC  (((`RCL_SCL_LOW_NS * `RCL_CLK_MHZ) + 999) / 1000)
`define RCL_SCL_HIGH_CYC (((`RCL_SCL_HIGH_NS * `RCL_CLK_MHZ) + 999) / 1000)
`define RCL_SU_STA_CYC   (((`RCL_SU_STA_NS * `RCL_CLK_MHZ) + 999) / 1000)
`define RCL_HD_STA_CYC   (((`RCL_HD_STA_NS * `RCL_CLK_MHZ) + 999) / 1000)
`define RCL_HD_DAT_CYC   (((`RCL_HD_DAT_NS * `RCL_CLK_MHZ) + 999) / 1000)
`define RCL_SU_STO_CYC   (((`RCL_SU_STO_NS * `RCL_CLK_MHZ) + 999) / 1000)

// ----------------------------------------
// Load timing
// ----------------------------------------
`define RCL_EEPROM_US    7500
`define RCL_EEPROM_CYC   (`RCL_EEPROM_US * `RCL_CLK_MHZ)
`define RCL_FIRST_ACC_MS 50

// ----------------------------------------
// Strap codes and EEPROM addressing
// ----------------------------------------
`define RCL_MODE_PIN     2'h0
`define RCL_MODE_MASTER  2'h1
`define RCL_EE_DEV       7'h50
`define RCL_EE_WADDR     8'h00

`endif

// file: rtl/rcl_pkg.sv
`default_nettype none
package rcl_pkg;
	typedef enum logic [1:0] {
		RCL_CMD_START,
		RCL_CMD_WRITE,
		RCL_CMD_READ,
		RCL_CMD_STOP
	} rcl_cmd_t;
endpackage
`default_nettype wire

// file: rtl/rcl_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcl_map.svh"
module rcl_top #(
	parameter int           CFG_BYTES = 16,
	parameter int           LOAD_CYC  = `RCL_EEPROM_CYC,
	parameter int           POR_CYC   = 16,
	parameter logic [6:0]   SLV_ADDR  = 7'h18
) (
	// Clock and reset
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_sys_rst,
	// Straps and load request
	input  wire logic [1:0]             i_mode_strap,
	input  wire logic [3:0]             i_dev_index,
	input  wire logic [3:0]             i_dev_count,
	input  wire logic [CFG_BYTES*8-1:0] i_strap_cfg,
	input  wire logic                   i_read_en_n,
	// Two-wire bus pins
	input  wire logic                   i_scl,
	output logic                        o_scl_oe,
	input  wire logic                   i_sda,
	output logic                        o_sda_oe,
	// Status and settings
	output logic                        o_all_done_n,
	output logic                        o_cfg_valid,
	output logic [CFG_BYTES*8-1:0]      o_cfg
);
	import rcl_pkg::*;

	localparam int SW = CFG_BYTES * 8 + 13;
	localparam int BW = $clog2(CFG_BYTES);

	typedef enum logic [3:0] {
		M_POR, M_IDLE, M_START, M_DEVW, M_WADDR, M_RSTA, M_DEVR,
		M_READ, M_STOP, M_BACK, M_WAIT, M_DONE, M_OFF
	} rcl_mst_st_t;

	typedef enum logic [1:0] {S_IDLE, S_ADDR, S_REG, S_DATA} rcl_slv_st_t;

	rcl_eng_if eng ();

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [SW-1:0] sync_a_q;
	logic [SW-1:0] sync_b_q;
	logic          scl_d_q;
	logic          sda_d_q;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_a_q <= '1;
			sync_b_q <= '1;
			scl_d_q  <= 1'b1;
			sda_d_q  <= 1'b1;
		end else begin
			sync_a_q <= {i_scl, i_sda, i_read_en_n, i_mode_strap, i_dev_index, i_dev_count, i_strap_cfg};
			sync_b_q <= sync_a_q;
			scl_d_q  <= sync_b_q[SW-1];
			sda_d_q  <= sync_b_q[SW-2];
		end
	end

	wire                   scl_s     = sync_b_q[SW-1];
	wire                   sda_s     = sync_b_q[SW-2];
	wire                   rd_en_n_s = sync_b_q[SW-3];
	wire [1:0]             mode_s    = sync_b_q[SW-4:SW-5];
	wire [3:0]             idx_s     = sync_b_q[SW-6:SW-9];
	wire [3:0]             cnt_s     = sync_b_q[SW-10:SW-13];
	wire [CFG_BYTES*8-1:0] strap_s   = sync_b_q[CFG_BYTES*8-1:0];
	wire                   scl_rise  = scl_s && !scl_d_q;
	wire                   scl_fall  = !scl_s && scl_d_q;
	wire                   bus_start = scl_s && scl_d_q && !sda_s && sda_d_q;
	wire                   bus_stop  = scl_s && scl_d_q && sda_s && !sda_d_q;

	assign eng.scl_s = scl_s;
	assign eng.sda_s = sda_s;

	rcl_i2c_engine u_eng (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.bus       (eng.eng)
	);

	// ----------------------------------------
	// Power-on and strap capture
	// ----------------------------------------
	logic [7:0] por_q;
	logic [1:0] mode_q;
	logic [3:0] idx_q;
	logic [3:0] devs_q;
	wire        por_done = (por_q == 8'(POR_CYC));

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			por_q  <= 8'h00;
			mode_q <= 2'h0;
			idx_q  <= 4'h0;
			devs_q <= 4'h1;
		end else if (!por_done) begin
			por_q  <= por_q + 8'h01;
			mode_q <= mode_s;
			idx_q  <= idx_s;
			devs_q <= (cnt_s == 4'h0) ? 4'h1 : cnt_s;
		end
	end

	wire pin_mode = (mode_q == `RCL_MODE_PIN);
	wire mst_mode = (mode_q == `RCL_MODE_MASTER);

	// ----------------------------------------
	// EEPROM load sequencer
	// ----------------------------------------
	rcl_mst_st_t st_q;
	rcl_mst_st_t nxt;
	logic        issued_q;
	logic        req_q;
	logic        retry_q;
	logic [BW-1:0] byte_q;
	logic [3:0]  slot_q;
	logic [20:0] tmr_q;
	logic [3:0]  tslot_q;
	logic        bus_busy_q;

	wire last_byte = (byte_q == BW'(CFG_BYTES - 1));
	wire last_rd   = last_byte && (slot_q == devs_q - 4'h1);
	wire time_up   = (tslot_q >= devs_q);
	wire own_slot  = (slot_q == idx_q);
	wire rd_done   = eng.done && (st_q == M_READ);

	assign eng.req   = req_q;
	assign eng.ack_n = last_rd;
	assign eng.cmd   = (st_q == M_START || st_q == M_RSTA) ? RCL_CMD_START :
	                   (st_q == M_READ) ? RCL_CMD_READ :
	                   (st_q == M_STOP) ? RCL_CMD_STOP : RCL_CMD_WRITE;
	assign eng.wdata = (st_q == M_DEVW) ? {`RCL_EE_DEV, 1'b0} :
	                   (st_q == M_DEVR) ? {`RCL_EE_DEV, 1'b1} : `RCL_EE_WADDR;

	always_comb begin
		nxt = st_q;
		unique case (st_q)
			M_POR:   nxt = !por_done ? M_POR : (mst_mode ? M_IDLE : M_OFF);
			M_IDLE:  nxt = !rd_en_n_s ? M_START : M_IDLE;
			M_START: nxt = M_DEVW;
			M_DEVW:  nxt = eng.nack ? M_STOP : M_WADDR;
			M_WADDR: nxt = eng.nack ? M_STOP : M_RSTA;
			M_RSTA:  nxt = M_DEVR;
			M_DEVR:  nxt = eng.nack ? M_STOP : M_READ;
			M_READ:  nxt = last_rd ? M_STOP : M_READ;
			M_STOP:  nxt = retry_q ? M_START : M_WAIT;
			M_BACK:  nxt = M_BACK;
			M_WAIT:  nxt = M_WAIT;
			M_DONE:  nxt = M_DONE;
			M_OFF:   nxt = M_OFF;
		endcase
	end

	wire nack_hit = eng.nack && (st_q == M_DEVW || st_q == M_WADDR || st_q == M_DEVR);

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q     <= M_POR;
			issued_q <= 1'b0;
			req_q    <= 1'b0;
			retry_q  <= 1'b0;
		end else begin
			req_q <= 1'b0;
			if (st_q inside {M_POR, M_IDLE}) begin
				st_q <= nxt;
			end else if (st_q == M_BACK) begin
				st_q <= bus_busy_q ? M_BACK : M_START;
			end else if (st_q == M_WAIT) begin
				st_q <= time_up ? M_DONE : M_WAIT;
			end else if (st_q inside {M_DONE, M_OFF}) begin
				st_q <= st_q;
			end else if (!issued_q) begin
				req_q    <= 1'b1;
				issued_q <= 1'b1;
			end else if (eng.done) begin
				issued_q <= 1'b0;
				if (eng.lost) begin
					st_q <= M_BACK;
				end else begin
					st_q <= nxt;
				end
				if (st_q == M_STOP) begin
					retry_q <= 1'b0;
				end else if (nack_hit) begin
					retry_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			byte_q  <= '0;
			slot_q  <= 4'h0;
			tmr_q   <= 21'h00_0000;
			tslot_q <= 4'h0;
		end else begin
			if (st_q == M_START) begin
				byte_q <= '0;
				slot_q <= 4'h0;
			end else if (rd_done && !eng.lost) begin
				byte_q <= last_byte ? '0 : byte_q + BW'(1);
				slot_q <= last_byte ? slot_q + 4'h1 : slot_q;
			end
			if (!(st_q inside {M_POR, M_IDLE, M_DONE, M_OFF}) && !time_up) begin
				tmr_q   <= (tmr_q == 21'(LOAD_CYC - 1)) ? 21'h00_0000 : tmr_q + 21'h00_0001;
				tslot_q <= (tmr_q == 21'(LOAD_CYC - 1)) ? tslot_q + 4'h1 : tslot_q;
			end
		end
	end

	// ----------------------------------------
	// Slave write receiver
	// ----------------------------------------
	rcl_slv_st_t sst_q;
	logic [7:0]  ssh_q;
	logic [3:0]  sbit_q;
	logic [7:0]  sptr_q;
	logic        sack_q;
	logic        swr_q;

	wire slv_en = !pin_mode && por_done;
	wire addr_ok = (ssh_q[7:1] == SLV_ADDR) && !ssh_q[0];

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sst_q      <= S_IDLE;
			ssh_q      <= 8'h00;
			sbit_q     <= 4'h0;
			sptr_q     <= 8'h00;
			sack_q     <= 1'b0;
			swr_q      <= 1'b0;
			bus_busy_q <= 1'b0;
		end else begin
			swr_q <= 1'b0;
			if (bus_start) begin
				bus_busy_q <= 1'b1;
			end else if (bus_stop) begin
				bus_busy_q <= 1'b0;
			end
			if (bus_start) begin
				sst_q  <= slv_en ? S_ADDR : S_IDLE;
				sbit_q <= 4'h0;
				sack_q <= 1'b0;
			end else if (bus_stop) begin
				sst_q  <= S_IDLE;
				sack_q <= 1'b0;
			end else if (sst_q != S_IDLE) begin
				if (scl_rise && !sack_q) begin
					ssh_q  <= {ssh_q[6:0], sda_s};
					sbit_q <= sbit_q + 4'h1;
				end else if (scl_fall && sack_q) begin
					sack_q <= 1'b0;
					sbit_q <= 4'h0;
				end else if (scl_fall && sbit_q == 4'h8) begin
					sbit_q <= 4'h0;
					unique case (sst_q)
						S_ADDR: begin
							sack_q <= addr_ok;
							sst_q  <= addr_ok ? S_REG : S_IDLE;
						end
						S_REG: begin
							sack_q <= 1'b1;
							sptr_q <= ssh_q;
							sst_q  <= S_DATA;
						end
						S_DATA: begin
							sack_q <= 1'b1;
							swr_q  <= 1'b1;
						end
						S_IDLE: sst_q <= S_IDLE;
					endcase
				end
				if (swr_q) begin
					sptr_q <= sptr_q + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// Settings store and outputs
	// ----------------------------------------
	logic [7:0] cfg_q [CFG_BYTES];

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int i = 0; i < CFG_BYTES; i++) begin
				cfg_q[i] <= 8'h00;
			end
		end else if (pin_mode) begin
			for (int i = 0; i < CFG_BYTES; i++) begin
				cfg_q[i] <= strap_s[i*8 +: 8];
			end
		end else if (swr_q && sptr_q < 8'(CFG_BYTES)) begin
			cfg_q[sptr_q[BW-1:0]] <= ssh_q;
		end else if (rd_done && !eng.lost && own_slot) begin
			cfg_q[byte_q] <= eng.rdata;
		end
	end

	for (genvar g = 0; g < CFG_BYTES; g++) begin : g_cfg
		assign o_cfg[g*8 +: 8] = cfg_q[g];
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_scl_oe     <= 1'b0;
			o_sda_oe     <= 1'b0;
			o_all_done_n <= 1'b1;
			o_cfg_valid  <= 1'b0;
		end else begin
			o_scl_oe     <= eng.scl_oe;
			o_sda_oe     <= eng.sda_oe || sack_q;
			o_all_done_n <= (st_q != M_DONE);
			o_cfg_valid  <= (st_q == M_DONE) || (por_done && !mst_mode);
		end
	end
endmodule
`default_nettype wire

// file: tb/rcl_ee_model.sv
`timescale 1ns/1ns
`default_nettype none
module rcl_ee_model #(
	parameter int DLY = 300
) (
	// Wire levels
	input  wire logic scl,
	input  wire logic sda,
	// Pull-down enable
	output logic      sda_oe
);
	logic [7:0] b;
	logic [7:0] ptr;
	logic [7:0] d;
	task automatic get_b;
		repeat (8) begin
			@(posedge scl);
			b = {b[6:0], sda};
		end
	endtask
	task automatic put(input logic v);
		@(negedge scl);
		#DLY sda_oe = v;
	endtask
	initial begin
		sda_oe = 1'b0;
		forever begin
			@(negedge sda iff scl === 1'b1);
			get_b();
			if (b == 8'hA0) begin
				put(1'b1);
				put(1'b0);
				get_b();
				ptr = b;
				put(1'b1);
				put(1'b0);
				@(negedge sda iff scl === 1'b1);
				get_b();
				put(1'b1);
				forever begin
					d = 8'h3C + ptr;
					for (int i = 7; i >= 0; i--) begin
						put(~d[i]);
					end
					put(1'b0);
					@(posedge scl);
					if (sda) begin
						break;
					end
					ptr = ptr + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/rcl_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rcl_top_properties #(
	parameter int CFG_BYTES = 16,
	parameter int LOAD_CYC  = 1875000,
	parameter int POR_CYC   = 16
) (
	// Clock, reset, straps
	input wire logic                   i_sys_clk,
	input wire logic                   i_sys_rst,
	input wire logic [1:0]             i_mode_strap,
	input wire logic [3:0]             i_dev_index,
	input wire logic [3:0]             i_dev_count,
	input wire logic [CFG_BYTES*8-1:0] i_strap_cfg,
	input wire logic                   i_read_en_n,
	// Bus and status
	input wire logic                   i_scl,
	input wire logic                   o_scl_oe,
	input wire logic                   i_sda,
	input wire logic                   o_sda_oe,
	input wire logic                   o_all_done_n,
	input wire logic                   o_cfg_valid,
	input wire logic [CFG_BYTES*8-1:0] o_cfg
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	logic        req_q;
	logic [31:0] since_q;
	logic [31:0] low_q;
	logic [31:0] high_q;
	logic [31:0] por_q;
	// ----------------------------------------
	// Cycle counters
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			req_q   <= 1'b0;
			since_q <= '0;
			low_q   <= '0;
			high_q  <= '0;
			por_q   <= '0;
		end else begin
			req_q   <= req_q | ~i_read_en_n;
			since_q <= (req_q | ~i_read_en_n) ? since_q + 1'b1 : '0;
			low_q   <= o_scl_oe ? low_q + 1'b1 : '0;
			high_q  <= o_scl_oe ? '0 : high_q + 1'b1;
			por_q   <= (por_q < 32'h0000_0400) ? por_q + 1'b1 : por_q;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_done_held: assert property (!o_all_done_n |=> !o_all_done_n)
		else $error("load complete rose again");
	a_load_time: assert property ($fell(o_all_done_n) |->
		since_q >= LOAD_CYC * ((i_dev_count == 4'h0) ? 1 : i_dev_count))
		else $error("load complete too early");
	a_no_req_idle: assert property (!req_q |-> o_all_done_n && !o_scl_oe)
		else $error("load ran without request");
	a_pin_quiet: assert property (i_mode_strap == 2'h0 |->
		!o_scl_oe && !o_sda_oe && o_all_done_n)
		else $error("bus activity in pin mode");
	a_pin_cfg: assert property (i_mode_strap == 2'h0 && $past(o_cfg_valid) |->
		o_cfg == i_strap_cfg)
		else $error("settings differ from straps");
	a_scl_low: assert property ($fell(o_scl_oe) |-> low_q == 475)
		else $error("clock low phase wrong");
	a_scl_high: assert property ($rose(o_scl_oe) |-> high_q >= 350)
		else $error("clock high phase short");
	a_valid_por: assert property (i_mode_strap != 2'h1 && por_q == POR_CYC + 12 |->
		o_cfg_valid)
		else $error("settings not valid after reset");
	a_ack_hold: assert property (i_mode_strap[1] && $rose(o_sda_oe) |-> o_sda_oe[*8])
		else $error("acknowledge too short");
	c_done: cover property ($fell(o_all_done_n));
	c_ack: cover property (i_mode_strap[1] && $rose(o_sda_oe));
	c_pin: cover property (i_mode_strap == 2'h0 && o_cfg_valid);
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int CB = 2;
	localparam int LC = 30000;
	localparam int PC = 16;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [1:0]  strap = 2'h0;
	logic [3:0]  idx = 4'h0;
	logic [3:0]  cnt = 4'h1;
	logic [15:0] scfg = 16'h0000;
	logic        ren_n = 1'b1;
	logic        m_scl = 1'b0;
	logic        m_sda = 1'b0;
	logic        ee_sda;
	logic        scl_oe;
	logic        sda_oe;
	logic        done_n;
	logic        valid;
	logic [15:0] cfg;
	wire         scl_w;
	wire         sda_w;
	int          err_total = 0;
	int          num_checks = 0;
	assign scl_w = ~(scl_oe | m_scl);
	assign sda_w = ~(sda_oe | m_sda | ee_sda);
	always #2 clk = ~clk;
	rcl_top #(.CFG_BYTES(CB), .LOAD_CYC(LC), .POR_CYC(PC)) u_rcl_top (
		.i_sys_clk(clk), .i_sys_rst(rst), .i_mode_strap(strap),
		.i_dev_index(idx), .i_dev_count(cnt), .i_strap_cfg(scfg),
		.i_read_en_n(ren_n), .i_scl(scl_w), .o_scl_oe(scl_oe),
		.i_sda(sda_w), .o_sda_oe(sda_oe), .o_all_done_n(done_n),
		.o_cfg_valid(valid), .o_cfg(cfg));
	rcl_ee_model u_rcl_ee_model (.scl(scl_w), .sda(sda_w), .sda_oe(ee_sda));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic hp;
		repeat (6) @(posedge clk);
	endtask
	task automatic restart(input logic [1:0] m);
		rst <= 1'b1;
		strap <= m;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (PC + 16) @(posedge clk);
	endtask
	task automatic m_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			m_sda <= ~b[i];
			hp();
			m_scl <= 1'b0;
			hp();
			m_scl <= 1'b1;
		end
		m_sda <= 1'b0;
		hp();
		m_scl <= 1'b0;
		repeat (3) @(posedge clk);
		ack = sda_oe;
		repeat (3) @(posedge clk);
		m_scl <= 1'b1;
	endtask
	task automatic m_xfer(input logic [31:0] bytes, input logic exp);
		logic ack;
		m_sda <= 1'b1;
		hp();
		m_scl <= 1'b1;
		for (int k = 3; k >= 0; k--) begin
			m_byte(bytes[8*k+:8], ack);
			check("slave ack", {15'h0000, ack}, {15'h0000, exp});
		end
		m_sda <= 1'b1;
		hp();
		m_scl <= 1'b0;
		hp();
		m_sda <= 1'b0;
		hp();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_pin;
		scfg <= 16'hA55A;
		restart(2'h0);
		check("pin cfg", cfg, 16'hA55A);
		check("pin valid", {15'h0000, valid}, 16'h0001);
		check("pin done", {15'h0000, done_n}, 16'h0001);
		m_xfer(32'h3000_1234, 1'b0);
		check("pin hold", cfg, 16'hA55A);
		$display("test pin finished");
	endtask
	task automatic test_slave(input logic [1:0] m);
		restart(m);
		m_xfer((m == 2'h2) ? 32'h3200_1111 : 32'h3100_1111, 1'b0);
		m_xfer(32'h3000_9669, 1'b1);
		check("slave cfg", cfg, 16'h6996);
		m_xfer(32'h3002_5555, 1'b1);
		check("slave range", cfg, 16'h6996);
		check("slave done", {15'h0000, done_n}, 16'h0001);
		$display("test slave mode %0d finished", m);
	endtask
	task automatic test_master;
		cnt <= 4'h2;
		idx <= 4'h1;
		restart(2'h1);
		repeat (200) @(posedge clk);
		check("idle done", {15'h0000, done_n}, 16'h0001);
		check("idle scl", {15'h0000, scl_oe}, 16'h0000);
		m_xfer(32'h3000_7788, 1'b1);
		check("early write", cfg, 16'h8877);
		ren_n <= 1'b0;
		repeat (2 * LC - 10) @(posedge clk);
		check("early done", {15'h0000, done_n}, 16'h0001);
		for (int k = 0; k < 60 && done_n !== 1'b0; k++) begin
			@(posedge clk);
		end
		check("done", {15'h0000, done_n}, 16'h0000);
		check("eeprom cfg", cfg, 16'h3F3E);
		check("master valid", {15'h0000, valid}, 16'h0001);
		m_xfer(32'h3000_1122, 1'b1);
		check("late write", cfg, 16'h2211);
		$display("test master finished");
	endtask
	initial begin
		test_pin();
		test_slave(2'h2);
		test_slave(2'h3);
		test_master();
		results();
	end
	initial begin
		#320000;
		err_total++;
		results();
	end
endmodule
bind rcl_top rcl_top_properties #(
	.CFG_BYTES(CFG_BYTES), .LOAD_CYC(LOAD_CYC), .POR_CYC(POR_CYC)
) u_rcl_top_properties (
	.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_mode_strap(i_mode_strap),
	.i_dev_index(i_dev_index), .i_dev_count(i_dev_count), .i_strap_cfg(i_strap_cfg),
	.i_read_en_n(i_read_en_n), .i_scl(i_scl), .o_scl_oe(o_scl_oe), .i_sda(i_sda),
	.o_sda_oe(o_sda_oe), .o_all_done_n(o_all_done_n), .o_cfg_valid(o_cfg_valid),
	.o_cfg(o_cfg));
`default_nettype wire
